// ==== rtl/pdm_pkg.sv ====
// Constants and carrier types for the power-down mode controller.
// Assumes one clock (ref_clk) and a synchronous active-low reset.
//
// Function
// - Two-bit field selects active, light sleep, regulator-off sleep or deep sleep.
// - A low-power mode starts only on a written go bit, never on field change.
// - Light and regulator-off sleep wake on reset, sleep timer or external interrupt.
// - Deep sleep wakes on reset or external interrupt only, not sleep timer.
// - Modes two and three switch digital regulator off; mode one keeps it on.
package pdm_pkg;

    localparam logic [1:0] PDM_MODE_ACTIVE = 2'h0;
    localparam logic [1:0] PDM_MODE_LIGHT = 2'h1;
    localparam logic [1:0] PDM_MODE_REG_OFF = 2'h2;
    localparam logic [1:0] PDM_MODE_DEEP = 2'h3;

    typedef enum logic [1:0] {
        PDM_ACTIVE,
        PDM_LIGHT,
        PDM_REG_OFF,
        PDM_DEEP
    } pdm_state_t;

    // Software-side control write
    typedef struct packed {
        logic power_down_go;
        logic [1:0] power_mode_select;
    } pdm_ctrl_t;

    // Wake sources
    typedef struct packed {
        logic sleep_timer_irq;
        logic ext_irq;
    } pdm_wake_t;

endpackage

// ==== rtl/pdm_wake_filter.sv ====
// Decides whether the present wake sources end the current state.
// Purely combinational; the top registers the outcome.
`timescale 1ns/1ps
module pdm_wake_filter
    import pdm_pkg::*;
(
    input wire pdm_state_t state,
    input wire pdm_wake_t wake,
    output logic wake_hit
);

    always_comb
    begin
        wake_hit = 1'b0;
        unique case (state)
            PDM_ACTIVE:
            begin
                wake_hit = 1'b0;
            end
            PDM_LIGHT, PDM_REG_OFF:
            begin
                wake_hit = wake.sleep_timer_irq | wake.ext_irq;
            end
            PDM_DEEP:
            begin
                wake_hit = wake.ext_irq;
            end
        endcase
    end

endmodule // pdm_wake_filter

// ==== rtl/pdm_ctrl.sv ====
// Power-down mode controller: holds the chip in a selected low-power mode
// until an allowed wake source arrives. Hardware reset is rst_n itself.
`timescale 1ns/1ps
module pdm_ctrl
    import pdm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic ctrl_wr,
    input wire pdm_ctrl_t ctrl_wdata,
    input wire pdm_wake_t wake_in,
    output logic [1:0] mode_ff,
    output logic sleeping_ff,
    output logic dig_reg_on_ff,
    output logic go_pending_ff,
    output logic wake_pulse_ff
);

    pdm_state_t state_ff;
    pdm_state_t nxt_state;
    logic wake_hit;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    function automatic pdm_state_t decode_mode(input logic [1:0] m);
        unique case (m)
            PDM_MODE_ACTIVE: decode_mode = PDM_ACTIVE;
            PDM_MODE_LIGHT: decode_mode = PDM_LIGHT;
            PDM_MODE_REG_OFF: decode_mode = PDM_REG_OFF;
            PDM_MODE_DEEP: decode_mode = PDM_DEEP;
        endcase
    endfunction

    // Explicit codes, so the output never leans on enum ordering
    function automatic logic [1:0] encode_mode(input pdm_state_t s);
        unique case (s)
            PDM_ACTIVE: encode_mode = PDM_MODE_ACTIVE;
            PDM_LIGHT: encode_mode = PDM_MODE_LIGHT;
            PDM_REG_OFF: encode_mode = PDM_MODE_REG_OFF;
            PDM_DEEP: encode_mode = PDM_MODE_DEEP;
        endcase
    endfunction

    pdm_wake_filter u_wake
    (
        .state(state_ff),
        .wake(wake_in),
        .wake_hit(wake_hit)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        if (state_ff == PDM_ACTIVE)
        begin
            // Field takes effect only with go; mode 0 with go stays active
            if (ctrl_wr && ctrl_wdata.power_down_go)
                nxt_state = decode_mode(ctrl_wdata.power_mode_select);
        end
        else if (wake_hit)
            nxt_state = PDM_ACTIVE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            state_ff <= PDM_ACTIVE;
        else if (clk_en)
            state_ff <= nxt_state;
    end

    // ----------------------------------------
    // Go request: held while asleep, cleared on wake
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            go_pending_ff <= 1'b0;
        else if (clk_en)
            go_pending_ff <= (nxt_state != PDM_ACTIVE);
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mode_ff <= PDM_MODE_ACTIVE;
            sleeping_ff <= 1'b0;
            dig_reg_on_ff <= 1'b1;
            wake_pulse_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            mode_ff <= encode_mode(nxt_state);
            sleeping_ff <= (nxt_state != PDM_ACTIVE);
            // Registers are lost when off; software must reconfigure
            dig_reg_on_ff <= !(nxt_state == PDM_REG_OFF || nxt_state == PDM_DEEP);
            wake_pulse_ff <= (state_ff != PDM_ACTIVE) && wake_hit;
        end
    end

    // ----------------------------------------
    // Check sequences
    // ----------------------------------------
    sequence s_go_write;
        clk_en && state_ff == PDM_ACTIVE && ctrl_wr && ctrl_wdata.power_down_go;
    endsequence

    sequence s_no_go;
        clk_en && !(ctrl_wr && ctrl_wdata.power_down_go);
    endsequence

    sequence s_wake_seen;
        clk_en && state_ff != PDM_ACTIVE && wake_hit;
    endsequence

    sequence s_asleep_quiet;
        clk_en && state_ff != PDM_ACTIVE && !wake_hit;
    endsequence

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_go_needed;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_ff == PDM_ACTIVE && !(ctrl_wr && ctrl_wdata.power_down_go))
        |=> !sleeping_ff;
    endproperty
    a_go_needed: assert property (p_go_needed) else $error("sleep without go");

    property p_light_wake;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_ff == PDM_LIGHT && wake_in.sleep_timer_irq) |=> !sleeping_ff;
    endproperty
    a_light_wake: assert property (p_light_wake) else $error("timer missed");

    property p_deep_timer;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_ff == PDM_DEEP && !wake_in.ext_irq) |=> sleeping_ff;
    endproperty
    a_deep_timer: assert property (p_deep_timer) else $error("deep left");

    property p_deep_ext;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_ff == PDM_DEEP && wake_in.ext_irq) |=> wake_pulse_ff && !go_pending_ff;
    endproperty
    a_deep_ext: assert property (p_deep_ext) else $error("ext missed");

    property p_reg_off;
        @(posedge ref_clk) disable iff (!rst_n)
        sleeping_ff && mode_ff != PDM_MODE_LIGHT |-> !dig_reg_on_ff;
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("regulator on");

    property p_reg_on;
        @(posedge ref_clk) disable iff (!rst_n)
        !sleeping_ff || mode_ff == PDM_MODE_LIGHT |-> dig_reg_on_ff;
    endproperty
    a_reg_on: assert property (p_reg_on) else $error("regulator off");

    property p_mode_decode;
        @(posedge ref_clk) disable iff (!rst_n)
        s_go_write |=> mode_ff == $past(ctrl_wdata.power_mode_select);
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("bad mode");

    property p_wake_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        wake_pulse_ff |-> !go_pending_ff && mode_ff == PDM_MODE_ACTIVE;
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("go kept");

    // ----------------------------------------
    // Checks on entry, wake and freeze
    // ----------------------------------------
    property p_go_start;
        @(posedge ref_clk) disable iff (!rst_n)
        s_go_write ##0 (ctrl_wdata.power_mode_select != PDM_MODE_ACTIVE)
        |=> sleeping_ff && go_pending_ff;
    endproperty
    a_go_start: assert property (p_go_start) else $error("go not taken");

    // Writes while asleep must not retarget the mode
    property p_asleep_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        s_asleep_quiet |=> sleeping_ff && $stable(mode_ff);
    endproperty
    a_asleep_hold: assert property (p_asleep_hold) else $error("mode moved asleep");

    property p_light_ext;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && (state_ff == PDM_LIGHT || state_ff == PDM_REG_OFF) && wake_in.ext_irq)
        |=> !sleeping_ff && wake_pulse_ff;
    endproperty
    a_light_ext: assert property (p_light_ext) else $error("ext wake missed");

    property p_reg_off_timer;
        @(posedge ref_clk) disable iff (!rst_n)
        (clk_en && state_ff == PDM_REG_OFF && wake_in.sleep_timer_irq)
        |=> !sleeping_ff && dig_reg_on_ff;
    endproperty
    a_reg_off_timer: assert property (p_reg_off_timer) else $error("timer wake missed");

    property p_pulse_once;
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && wake_pulse_ff |=> !wake_pulse_ff;
    endproperty
    a_pulse_once: assert property (p_pulse_once) else $error("wake pulse stuck");

    // A wake consumes the request; no silent re-entry
    property p_no_reentry;
        @(posedge ref_clk) disable iff (!rst_n)
        s_wake_seen ##1 s_no_go |=> !sleeping_ff && !go_pending_ff;
    endproperty
    a_no_reentry: assert property (p_no_reentry) else $error("sleep without new go");

    property p_idle_outputs;
        @(posedge ref_clk) disable iff (!rst_n)
        !sleeping_ff |-> mode_ff == PDM_MODE_ACTIVE && !go_pending_ff && dig_reg_on_ff;
    endproperty
    a_idle_outputs: assert property (p_idle_outputs) else $error("idle outputs wrong");

    // Clock enable low freezes everything, outputs included
    property p_freeze;
        @(posedge ref_clk) disable iff (!rst_n)
        !clk_en |=> $stable(mode_ff) && $stable(sleeping_ff) && $stable(dig_reg_on_ff)
            && $stable(go_pending_ff) && $stable(wake_pulse_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

endmodule // pdm_ctrl

// ==== bench/power_down_mode_control_tb_top.sv ====
// Self-checking bench for the power-down mode controller.
// Assumes pdm_pkg and pdm_ctrl compiled first; inputs move on falling edges.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module power_down_mode_control_tb_top
    import pdm_pkg::*;
;
    localparam pdm_wake_t W_TMR = 2'h2;
    localparam pdm_wake_t W_EXT = 2'h1;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic ctrl_wr = 1'b0;
    pdm_ctrl_t ctrl_wdata = '0;
    pdm_wake_t wake_in = '0;
    logic [1:0] mode_ff;
    logic sleeping_ff, dig_reg_on_ff, go_pending_ff, wake_pulse_ff;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    pdm_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .ctrl_wr(ctrl_wr),
        .ctrl_wdata(ctrl_wdata), .wake_in(wake_in), .mode_ff(mode_ff),
        .sleeping_ff(sleeping_ff), .dig_reg_on_ff(dig_reg_on_ff),
        .go_pending_ff(go_pending_ff), .wake_pulse_ff(wake_pulse_ff));
    // ----------------------------------------
    // Drivers and checks
    // ----------------------------------------
    task automatic expect_state(input logic [1:0] m, input logic on, input logic pulse);
        `CHK("mode_ff", m, mode_ff)
        `CHK("sleeping_ff", (m != PDM_MODE_ACTIVE), sleeping_ff)
        `CHK("dig_reg_on_ff", on, dig_reg_on_ff)
        `CHK("go_pending_ff", (m != PDM_MODE_ACTIVE), go_pending_ff)
        `CHK("wake_pulse_ff", pulse, wake_pulse_ff)
    endtask
    task automatic write_ctrl(input logic go, input logic [1:0] sel);
        @(negedge ref_clk);
        ctrl_wr = 1'b1;
        ctrl_wdata = '{power_down_go: go, power_mode_select: sel};
        @(negedge ref_clk);
        ctrl_wr = 1'b0;
    endtask
    task automatic pulse_wake(input pdm_wake_t w);
        @(negedge ref_clk);
        wake_in = w;
        @(negedge ref_clk);
        wake_in = '0;
    endtask
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_light_and_reg_off();
        for (int m = 1; m <= 2; m++)
        begin
            write_ctrl(1'b1, m[1:0]);
            expect_state(m[1:0], (m == 1), 1'b0);
            pulse_wake(W_TMR);
            expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b1);
            write_ctrl(1'b1, m[1:0]);
            pulse_wake(W_EXT);
            expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b1);
        end
        $display("t_light_and_reg_off done");
    endtask
    task automatic t_deep();
        write_ctrl(1'b1, PDM_MODE_DEEP);
        expect_state(PDM_MODE_DEEP, 1'b0, 1'b0);
        pulse_wake(W_TMR);
        expect_state(PDM_MODE_DEEP, 1'b0, 1'b0);
        pulse_wake(W_EXT);
        expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b1);
        @(negedge ref_clk);
        expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b0);
        write_ctrl(1'b1, PDM_MODE_DEEP);
        expect_state(PDM_MODE_DEEP, 1'b0, 1'b0);
        @(negedge ref_clk);
        rst_n = 1'b0;
        @(negedge ref_clk);
        rst_n = 1'b1;
        expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b0);
        $display("t_deep done");
    endtask
    task automatic t_refused();
        write_ctrl(1'b0, PDM_MODE_REG_OFF);
        expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b0);
        write_ctrl(1'b1, PDM_MODE_ACTIVE);
        expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b0);
        write_ctrl(1'b1, PDM_MODE_LIGHT);
        write_ctrl(1'b1, PDM_MODE_DEEP);
        expect_state(PDM_MODE_LIGHT, 1'b1, 1'b0);
        clk_en = 1'b0;
        pulse_wake(W_EXT);
        expect_state(PDM_MODE_LIGHT, 1'b1, 1'b0);
        clk_en = 1'b1;
        pulse_wake(W_EXT);
        expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b1);
        $display("t_refused done");
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        expect_state(PDM_MODE_ACTIVE, 1'b1, 1'b0);
        t_light_and_reg_off();
        t_deep();
        t_refused();
        tally_and_finish();
    end
endmodule // power_down_mode_control_tb_top
